/* stbd_pkg.sv */
// constants for the one- and two-channel texel block decoder
package stbd_pkg;
  // channel word field positions
  localparam int BLOCK_BYTES = 8;
  localparam int WORD_W = 64;
  localparam int BASE_MSB = 63;
  localparam int BASE_LSB = 56;
  localparam int MULT_MSB = 55;
  localparam int MULT_LSB = 52;
  localparam int TBL_MSB = 51;
  localparam int TBL_LSB = 48;
  localparam int IDX_MSB = 47;
  localparam int IDX_W = 3;
  localparam int TEXELS = 16;
  localparam int RES_W = 11;
  localparam int WIDE_W = 16;
  localparam int SCALE_SH = 3;
  localparam int SIGNED_REP_SH = 5;
  localparam int UNSIGNED_REP_SH = 6;
  // clamp bounds and offsets
  localparam logic signed [13:0] S_MAX = 14'sh03FF;
  localparam logic signed [13:0] S_MIN = -14'sh03FF;
  localparam logic signed [13:0] U_MAX = 14'sh07FF;
  localparam logic signed [13:0] U_MIN = 14'sh0000;
  localparam logic signed [13:0] U_OFFSET = 14'sh0004;
  localparam logic signed [7:0] BASE_FORBIDDEN = 8'sh80;
  localparam logic signed [7:0] BASE_FLOOR = 8'sh81;
  localparam int FIFO_DEPTH = 8;

  // block formats handled by the decoder
  typedef enum logic [1:0] {
    stbd_single_channel_unsigned_format,
    stbd_single_channel_signed_format,
    stbd_two_channel_unsigned_format
  } stbd_fmt_e;
endpackage

/* stbd_fifo.sv */
// small valid/ready fifo used on the request path
`timescale 1ns/10ps
module stbd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // pointer wrap relies on a power-of-two depth, so refuse anything else at elaboration
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
    $error("stbd_fifo depth must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } stbd_fifo_s;

  stbd_fifo_s st_r;
  stbd_fifo_s st_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  // full and empty come straight from the occupancy count
  assign in_ready = (st_r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_r.cnt != '0);
  assign out_data = mem[st_r.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer and count update
  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.wr = st_r.wr + 1'b1;
    end
    if (pop) begin
      st_nxt.rd = st_r.rd + 1'b1;
    end
    if (push && !pop) begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end else if (pop && !push) begin
      st_nxt.cnt = st_r.cnt - 1'b1;
    end
  end

  // storage has no reset; only pointers and count need a defined value
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
    if (push) begin
      mem[st_r.wr] <= in_data;
    end
  end
endmodule

/* stbd_channel.sv */
// one channel: fields, modifier lookup, sum, clamp and widening
`timescale 1ns/10ps
module stbd_channel (
  input wire logic [63:0] word,
  input wire logic [3:0] texel,
  input wire logic is_signed,
  output logic [10:0] value11,
  output logic [15:0] value16
);
  logic [7:0] base_f;
  logic [3:0] mult_f;
  logic [3:0] tbl_f;
  logic [2:0] pix_idx;
  logic [5:0] idx_lsb;
  logic signed [7:0] base_s;
  logic signed [13:0] base_term;
  logic signed [13:0] mod_term;
  logic signed [13:0] sum;
  logic signed [13:0] clamped;
  logic signed [4:0] modifier;
  logic [10:0] mag;
  logic [15:0] mag16;

  // modifier table entry, row by table index, column by pixel index
  function automatic logic signed [4:0] mod_lookup(input logic [3:0] t, input logic [2:0] i);
    logic signed [4:0] row [8];
    case (t)
      4'h0: row = '{-5'sd3, -5'sd6, -5'sd9, -5'sd15, 5'sd2, 5'sd5, 5'sd8, 5'sd14};
      4'h1: row = '{-5'sd3, -5'sd7, -5'sd10, -5'sd13, 5'sd2, 5'sd6, 5'sd9, 5'sd12};
      4'h2: row = '{-5'sd2, -5'sd5, -5'sd8, -5'sd13, 5'sd1, 5'sd4, 5'sd7, 5'sd12};
      4'h3: row = '{-5'sd2, -5'sd4, -5'sd6, -5'sd13, 5'sd1, 5'sd3, 5'sd5, 5'sd12};
      4'h4: row = '{-5'sd3, -5'sd6, -5'sd8, -5'sd12, 5'sd2, 5'sd5, 5'sd7, 5'sd11};
      4'h5: row = '{-5'sd3, -5'sd7, -5'sd9, -5'sd11, 5'sd2, 5'sd6, 5'sd8, 5'sd10};
      4'h6: row = '{-5'sd4, -5'sd7, -5'sd8, -5'sd11, 5'sd3, 5'sd6, 5'sd7, 5'sd10};
      4'h7: row = '{-5'sd3, -5'sd5, -5'sd8, -5'sd11, 5'sd2, 5'sd4, 5'sd7, 5'sd10};
      4'h8: row = '{-5'sd2, -5'sd6, -5'sd8, -5'sd10, 5'sd1, 5'sd5, 5'sd7, 5'sd9};
      4'h9: row = '{-5'sd2, -5'sd5, -5'sd8, -5'sd10, 5'sd1, 5'sd4, 5'sd7, 5'sd9};
      4'hA: row = '{-5'sd2, -5'sd4, -5'sd8, -5'sd10, 5'sd1, 5'sd3, 5'sd7, 5'sd9};
      4'hB: row = '{-5'sd2, -5'sd5, -5'sd7, -5'sd10, 5'sd1, 5'sd4, 5'sd6, 5'sd9};
      4'hC: row = '{-5'sd3, -5'sd4, -5'sd7, -5'sd10, 5'sd2, 5'sd3, 5'sd6, 5'sd9};
      4'hD: row = '{-5'sd1, -5'sd2, -5'sd3, -5'sd10, 5'sd0, 5'sd1, 5'sd2, 5'sd9};
      4'hE: row = '{-5'sd4, -5'sd6, -5'sd8, -5'sd9, 5'sd3, 5'sd5, 5'sd7, 5'sd8};
      default: row = '{-5'sd3, -5'sd5, -5'sd7, -5'sd9, 5'sd2, 5'sd4, 5'sd6, 5'sd8};
    endcase
    return row[i];
  endfunction

  // field extraction; texel 0 (pixel a) owns the top index field
  assign base_f = word[stbd_pkg::BASE_MSB:stbd_pkg::BASE_LSB];
  assign mult_f = word[stbd_pkg::MULT_MSB:stbd_pkg::MULT_LSB];
  assign tbl_f = word[stbd_pkg::TBL_MSB:stbd_pkg::TBL_LSB];
  assign idx_lsb = 6'(stbd_pkg::IDX_MSB + 1 - stbd_pkg::IDX_W) - (6'(texel) * 6'h03);
  assign pix_idx = word[idx_lsb +: 3];
  assign modifier = mod_lookup(tbl_f, pix_idx);
  // a forbidden -128 base is folded onto -127
  assign base_s = (base_f == stbd_pkg::BASE_FORBIDDEN) ? stbd_pkg::BASE_FLOOR : $signed(base_f);

  // shared sum path; the modes differ only in base sign, offset, clamp and widening
  always_comb begin
    if (is_signed) begin
      base_term = 14'(base_s) <<< stbd_pkg::SCALE_SH;
    end else begin
      base_term = ($signed({6'h00, base_f}) <<< stbd_pkg::SCALE_SH) + stbd_pkg::U_OFFSET;
    end
    if (mult_f == 4'h0) begin
      mod_term = 14'(modifier);
    end else begin
      // both factors widened first so the product cannot wrap at five bits
      mod_term = (14'(modifier) * 14'($signed({1'b0, mult_f}))) <<< stbd_pkg::SCALE_SH;
    end
    sum = base_term + mod_term;
    if (is_signed) begin
      if (sum > stbd_pkg::S_MAX) begin
        clamped = stbd_pkg::S_MAX;
      end else if (sum < stbd_pkg::S_MIN) begin
        clamped = stbd_pkg::S_MIN;
      end else begin
        clamped = sum;
      end
    end else begin
      if (sum > stbd_pkg::U_MAX) begin
        clamped = stbd_pkg::U_MAX;
      end else if (sum < stbd_pkg::U_MIN) begin
        clamped = stbd_pkg::U_MIN;
      end else begin
        clamped = sum;
      end
    end
  end

  // exact 11-bit result, never truncated
  assign value11 = clamped[10:0];

  // widening: signed replicates the magnitude, then restores the sign
  always_comb begin
    mag = clamped[13] ? 11'(-clamped) : clamped[10:0];
    if (is_signed) begin
      mag16 = (16'(mag) << stbd_pkg::SIGNED_REP_SH) + 16'(mag >> stbd_pkg::SIGNED_REP_SH);
      value16 = clamped[13] ? 16'(-mag16) : mag16;
    end else begin
      mag16 = (16'(mag) << stbd_pkg::SIGNED_REP_SH) + 16'(mag >> stbd_pkg::UNSIGNED_REP_SH);
      value16 = mag16;
    end
  end
endmodule

/* stbd_decoder.sv */
// texel block decoder top: byte assembly, request fifo, two channels, output register
`timescale 1ns/10ps
module stbd_decoder #(
  parameter int DEPTH = stbd_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [127:0] req_bytes,
  input wire logic [1:0] req_format,
  input wire logic [3:0] req_texel,
  output logic rsp_valid,
  input wire logic rsp_ready,
  output logic [10:0] rsp_red11,
  output logic [10:0] rsp_green11,
  output logic [15:0] rsp_red16,
  output logic [15:0] rsp_green16,
  output logic rsp_two_channel
);
  localparam int REQ_W = 128 + 2 + 4;

  // refused at elaboration rather than discovered in simulation
  if (DEPTH < 2) begin : g_depth_check
    $error("stbd_decoder needs a request fifo of at least two words");
  end

  typedef struct packed {
    logic valid;
    logic two;
    logic [10:0] r11;
    logic [10:0] g11;
    logic [15:0] r16;
    logic [15:0] g16;
  } stbd_out_s;

  stbd_out_s st_r;
  stbd_out_s st_nxt;
  logic q_valid;
  logic q_ready;
  logic [REQ_W-1:0] q_data;
  logic [127:0] q_bytes;
  logic [1:0] q_fmt;
  logic [3:0] q_texel;
  logic [63:0] red_channel_word;
  logic [63:0] green_channel_word;
  logic is_signed;
  logic [10:0] red11;
  logic [10:0] green11;
  logic [15:0] red16;
  logic [15:0] green16;

  // byte n of the block sits at req_bytes[8n+7:8n]; byte 0 is the lowest address
  function automatic logic [63:0] pack_word(input logic [127:0] b, input int first);
    logic [63:0] w;
    w = '0;
    for (int k = 0; k < stbd_pkg::BLOCK_BYTES; k++) begin
      w = {w[55:0], b[(first + k) * 8 +: 8]};
    end
    return w;
  endfunction

  // requests are buffered so the sampler can run ahead of a stalled consumer
  stbd_fifo #(
    .WIDTH(REQ_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data({req_bytes, req_format, req_texel}),
    .out_valid(q_valid),
    .out_ready(q_ready),
    .out_data(q_data)
  );

  assign q_bytes = q_data[REQ_W-1 -: 128];
  assign q_fmt = q_data[5:4];
  assign q_texel = q_data[3:0];

  // red from the first eight bytes, green from the second eight
  assign red_channel_word = pack_word(q_bytes, 0);
  assign green_channel_word = pack_word(q_bytes, stbd_pkg::BLOCK_BYTES);
  assign is_signed = (q_fmt == 2'(stbd_pkg::stbd_single_channel_signed_format));

  stbd_channel u_red (
    .word(red_channel_word),
    .texel(q_texel),
    .is_signed(is_signed),
    .value11(red11),
    .value16(red16)
  );

  // green always decodes unsigned: signed two-channel is not handled
  stbd_channel u_green (
    .word(green_channel_word),
    .texel(q_texel),
    .is_signed(1'b0),
    .value11(green11),
    .value16(green16)
  );

  // one-stage output register; it refills in the same cycle it drains
  assign q_ready = !st_r.valid || rsp_ready;

  always_comb begin
    st_nxt = st_r;
    if (rsp_ready) begin
      st_nxt.valid = 1'b0;
    end
    if (q_valid && q_ready) begin
      st_nxt.valid = 1'b1;
      st_nxt.two = (q_fmt == 2'(stbd_pkg::stbd_two_channel_unsigned_format));
      st_nxt.r11 = red11;
      st_nxt.r16 = red16;
      // green reads zero unless the block really has two channels
      st_nxt.g11 = (q_fmt == 2'(stbd_pkg::stbd_two_channel_unsigned_format)) ? green11 : 11'h000;
      st_nxt.g16 = (q_fmt == 2'(stbd_pkg::stbd_two_channel_unsigned_format)) ? green16 : 16'h0000;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rsp_valid = st_r.valid;
  assign rsp_two_channel = st_r.two;
  assign rsp_red11 = st_r.r11;
  assign rsp_green11 = st_r.g11;
  assign rsp_red16 = st_r.r16;
  assign rsp_green16 = st_r.g16;
endmodule

/* stbd_decoder_checker.sv */
// handshake, widening and buffering assertions for the texel block decoder
`timescale 1ns/10ps
module stbd_decoder_checker #(
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input wire logic [10:0] rsp_red11,
  input wire logic [10:0] rsp_green11,
  input wire logic [15:0] rsp_red16,
  input wire logic [15:0] rsp_green16,
  input wire logic rsp_two_channel
);
  logic [7:0] pend_r;
  // requests taken but not yet handed over; wide enough for fifo plus output stage
  always_ff @(posedge clk) begin
    if (rst) pend_r <= 8'h00;
    else pend_r <= pend_r + 8'(req_valid && req_ready) - 8'(rsp_valid && rsp_ready);
  end
  // unsigned replication: value shifted left five plus value shifted right six
  function automatic logic [15:0] uw(logic [10:0] x);
    return {x, 5'h00} + 16'(x >> 6);
  endfunction
  // signed replication works on the magnitude, then restores the sign
  function automatic logic [15:0] sw(logic [10:0] x);
    logic [10:0] m;
    logic [15:0] w;
    m = x[10] ? -x : x;
    w = {m, 5'h00} + 16'(m >> 5);
    return x[10] ? -w : w;
  endfunction
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_take; req_valid && req_ready; endsequence
  sequence s_take_idle; req_valid && req_ready && pend_r == 8'h00; endsequence
  sequence s_first; !rsp_valid ##1 rsp_valid; endsequence
  reset_idle_a: assert property (disable iff (1'b0) rst |=> !rsp_valid && req_ready)
    else $error("outputs not idle after reset");
  min_latency_a: assert property (s_take_idle |=> s_first)
    else $error("answer not two edges after take");
  hold_stable_a: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_red11) && $stable(rsp_red16)
    && $stable(rsp_green11) && $stable(rsp_green16) && $stable(rsp_two_channel))
    else $error("answer changed while stalled");
  answer_bound_a: assert property (s_take |-> ##[1:40] rsp_valid)
    else $error("no answer after take");
  spurious_answer_a: assert property (rsp_valid |-> pend_r != 8'h00)
    else $error("answer with nothing pending");
  refuse_full_a: assert property (!req_ready |-> pend_r >= 8'(DEPTH))
    else $error("refused while not full");
  green_zero_a: assert property (rsp_valid && !rsp_two_channel |-> rsp_green11 == 11'h000 && rsp_green16 == 16'h0000)
    else $error("green not zero for one channel");
  green_widen_a: assert property (rsp_valid && rsp_two_channel |-> rsp_green16 == uw(rsp_green11))
    else $error("green widening wrong");
  red_widen_a: assert property (rsp_valid |-> rsp_red16 == uw(rsp_red11) || rsp_red16 == sw(rsp_red11))
    else $error("red widening wrong");
endmodule

/* stbd_sink_model.sv */
// sampling-side model: takes answers, stalls on command
`timescale 1ns/10ps
module stbd_sink_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic stall,
  output logic rsp_ready
);
  // registered ready so it never changes near the sampling edge
  always_ff @(posedge clk) begin
    if (rst) rsp_ready <= 1'b0;
    else rsp_ready <= !stall;
  end
endmodule

/* stbd_decoder_tb.sv */
// self-checking bench for the texel block decoder
`timescale 1ns/10ps
module stbd_decoder_tb;
  localparam int DEPTH = 8;
  logic clk = 1'b0, rst, req_valid, req_ready, rsp_valid, rsp_ready, rsp_two_channel, stall, full_seen;
  logic [127:0] req_bytes;
  logic [1:0] req_format;
  logic [3:0] req_texel;
  logic [10:0] rsp_red11, rsp_green11;
  logic [15:0] rsp_red16, rsp_green16, g [5];
  int num_errors = 0, check_count = 0;
  stbd_decoder #(.DEPTH(DEPTH)) u_dut (.clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
    .req_bytes(req_bytes), .req_format(req_format), .req_texel(req_texel), .rsp_valid(rsp_valid),
    .rsp_ready(rsp_ready), .rsp_red11(rsp_red11), .rsp_green11(rsp_green11), .rsp_red16(rsp_red16),
    .rsp_green16(rsp_green16), .rsp_two_channel(rsp_two_channel));
  stbd_sink_model u_sink (.clk(clk), .rst(rst), .stall(stall), .rsp_ready(rsp_ready));
  always #2 clk = ~clk;
  task automatic check(string n, logic [15:0] got, logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic close_out;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // table 13 block; only the chosen texel gets a nonzero index
  function automatic logic [63:0] mk(logic [7:0] b, logic [3:0] m, int t, logic [2:0] ix);
    logic [63:0] w;
    w = {b, m, 4'hD, 48'h0};
    w[47-3*t -: 3] = ix;
    return w;
  endfunction
  // lowest address byte carries the top of each word
  task automatic send(logic [1:0] f, logic [63:0] r, logic [63:0] gw, int t);
    for (int n = 0; n < 8; n++) begin
      req_bytes[8*n +: 8] <= r[63-8*n -: 8];
      req_bytes[64+8*n +: 8] <= gw[63-8*n -: 8];
    end
    req_valid <= 1'b1;
    req_format <= f;
    req_texel <= 4'(t);
    do begin
      @(negedge clk);
      if (!req_ready) full_seen = 1'b1;
    end while (!req_ready);
    @(posedge clk);
  endtask
  // waits for a handshake, captures at the falling edge before the accepting edge
  // a missing answer counts as a mismatch instead of passing stale outputs on
  task automatic get_rsp;
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < 200 && !hit; k++) begin
      @(negedge clk);
      hit = (rsp_valid === 1'b1 && rsp_ready === 1'b1);
    end
    check("answer handshake", 16'(hit), 16'h0001);
    g = '{rsp_red11, rsp_red16, rsp_green11, rsp_green16, rsp_two_channel};
    @(posedge clk);
  endtask
  task automatic run(logic [1:0] f, logic [63:0] r, logic [63:0] gw, int t, logic [15:0] e[5]);
    send(f, r, gw, t);
    req_valid <= 1'b0;
    get_rsp();
    foreach (e[i]) check("answer field", g[i], e[i]);
  endtask
  task automatic t_signed;
    run(2'h1, mk(8'h3C, 4'h2, 1, 3'h3), '0, 1, '{16'h0140, 16'h280A, 0, 0, 0});
    run(2'h1, mk(8'h3C, 4'h0, 1, 3'h3), '0, 1, '{16'h01D6, 16'h3ACE, 0, 0, 0});
    run(2'h1, mk(8'h80, 4'h0, 0, 3'h4), '0, 0, '{16'h0408, 16'h80E1, 0, 0, 0});
    run(2'h1, mk(8'h81, 4'hF, 15, 3'h3), '0, 15, '{16'h0401, 16'h8001, 0, 0, 0});
    run(2'h1, mk(8'h7F, 4'hF, 5, 3'h7), '0, 5, '{16'h03FF, 16'h7FFF, 0, 0, 0});
    // flipping one table bit turns table 13 into table 15
    run(2'h1, mk(8'h7F, 4'h1, 3, 3'h1) ^ 64'h0002_0000_0000_0000, '0, 3,
      '{16'h03D0, 16'h7A1E, 0, 0, 0});
  endtask
  task automatic t_unsigned;
    run(2'h0, mk(8'h67, 4'h2, 1, 3'h3), '0, 1, '{16'h029C, 16'h538A, 0, 0, 0});
    run(2'h3, mk(8'h00, 4'hF, 2, 3'h3), '0, 2, '{16'h0000, 16'h0000, 0, 0, 0});
    run(2'h0, mk(8'h80, 4'h0, 4, 3'h4), '0, 4, '{16'h0404, 16'h8090, 0, 0, 0});
  endtask
  task automatic t_two;
    run(2'h2, mk(8'h67, 4'h0, 7, 3'h3), mk(8'hFF, 4'hF, 7, 3'h7), 7,
      '{16'h0332, 16'h664C, 16'h07FF, 16'hFFFF, 16'h0001});
  endtask
  // sink stalls while twelve requests are offered and nine queue up (fifo plus output stage), then drains in order
  task automatic t_back;
    full_seen = 1'b0;
    stall <= 1'b1;
    fork
      begin
        for (int i = 0; i < 12; i++) send(2'h1, mk(8'(i), 4'h0, 0, 3'h4), '0, 0);
        req_valid <= 1'b0;
      end
      begin
        repeat (30) @(posedge clk);
        check("refused when full", 16'(full_seen), 16'h0001);
        stall <= 1'b0;
        for (int i = 0; i < 12; i++) begin
          get_rsp();
          check("drain order", g[0], 16'(i * 8));
        end
      end
    join
  endtask
  initial begin
    rst = 1'b1;
    stall = 1'b0;
    req_valid = 1'b0;
    req_bytes = '0;
    req_format = 2'h0;
    req_texel = 4'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_signed();
    t_unsigned();
    t_two();
    t_back();
    close_out();
  end
  // watchdog well beyond the hundred or so cycles the scenarios need
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    close_out();
  end
endmodule
bind stbd_decoder stbd_decoder_checker #(.DEPTH(DEPTH)) u_chk (.clk(clk), .rst(rst), .req_valid(req_valid),
  .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_red11(rsp_red11),
  .rsp_green11(rsp_green11), .rsp_red16(rsp_red16), .rsp_green16(rsp_green16), .rsp_two_channel(rsp_two_channel));
